// *** core/asra_defs.svh ***
/*
 Constants of the serial register front-end: addresses, field positions,
 reset values and bit counts. Assumes inclusion by bare name.
*/
`ifndef ASRA_DEFS_SVH
`define ASRA_DEFS_SVH
`define ASRA_A_CMD        3'h0
`define ASRA_A_MODE       3'h1
`define ASRA_A_CFG        3'h2
`define ASRA_A_DATA       3'h3
`define ASRA_A_ID         3'h4
`define ASRA_A_GPO        3'h5
`define ASRA_A_OFF        3'h6
`define ASRA_A_FS         3'h7
`define ASRA_CMD_DIR      6
`define ASRA_CMD_AHI      5
`define ASRA_CMD_ALO      3
`define ASRA_CMD_CONTINUOUS_READ_BIT    2
`define ASRA_ST_RDY       7
`define ASRA_MODE_APPEND  20
`define ASRA_RST_CMD      8'h00
`define ASRA_RST_STATUS   8'h80
`define ASRA_RST_MODE     24'h080060
`define ASRA_RST_CFG      24'h000117
`define ASRA_RST_DATA     24'h000000
`define ASRA_RST_GPO      8'h00
`define ASRA_RST_OFF      24'h800000
`define ASRA_LEN_BYTE     6'h08
`define ASRA_LEN_WORD     6'h18
`define ASRA_LEN_LONG     6'h20
`define ASRA_CMD_LAST     6'h07
`define ASRA_ONES_RESET   6'h28
`endif

// *** core/asra_pkg.sv ***
/*
 Types of the serial register front-end.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package asra_pkg;
   typedef enum {
      ASRA_IDLE,
      ASRA_CMD,
      ASRA_WRITE,
      ASRA_READ,
      ASRA_CONTINUOUS_READ_BIT
   } asra_state_e;
   typedef logic [2:0] asra_addr_t;
endpackage : asra_pkg
`default_nettype wire

// *** core/asra_regs.sv ***
/*
 Register file on core_clk: takes writes and read events from the serial
 engine by toggles, holds the registers and the conversion result.
 Assumes the engine holds write address and data stable between toggles.
*/
`default_nettype none
`include "asra_defs.svh"
module asra_regs #(
   // Arbitrary identity value
   parameter logic [7:0]  PART_ID  = 8'h5A,
   parameter logic [23:0] FS_RESET = 24'h000000
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // From the serial engine, other clock
   input  wire logic             wr_tgl,
   input  wire asra_pkg::asra_addr_t wr_addr,
   input  wire logic [23:0]      wr_data,
   input  wire logic             rd_tgl,
   input  wire logic             prst_tgl,
   input  wire logic             link_busy,
   // Converter side
   input  wire logic             result_valid,
   input  wire logic [23:0]      result,
   input  wire logic [6:0]       result_flags,
   // Registers
   output logic [7:0]            status_q,
   output logic [23:0]           mode_q,
   output logic [23:0]           cfg_q,
   output logic [23:0]           data_q,
   output logic [7:0]            ident_q,
   output logic [7:0]            gpo_q,
   output logic [23:0]           off_q,
   output logic [23:0]           fs_q,
   output logic                  filter_restart_q,
   output logic                  part_reset_q
);
   import asra_pkg::*;
   logic [3:0]  meta_q, sync_q, last_q;
   logic [30:0] hold_q;
   logic        pend_q;
   wire  [3:0]  async_w = {link_busy, prst_tgl, rd_tgl, wr_tgl};
   genvar i;
   for (i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
            last_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= async_w[i];
            sync_q[i] <= meta_q[i];
            last_q[i] <= sync_q[i];
         end
      end
   end
   wire wr_ev   = sync_q[0] ^ last_q[0];
   wire rd_ev   = sync_q[1] ^ last_q[1];
   wire prst_ev = sync_q[2] ^ last_q[2];
   wire busy_s  = sync_q[3];
   wire mode_wr = wr_ev && (wr_addr == `ASRA_A_MODE);
   // Result is published only while no access is in flight
   wire publish = pend_q && !busy_s;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= `ASRA_RST_MODE;
         cfg_q  <= `ASRA_RST_CFG;
         gpo_q  <= `ASRA_RST_GPO;
         off_q  <= `ASRA_RST_OFF;
         fs_q   <= FS_RESET;
      end else if (prst_ev) begin
         mode_q <= `ASRA_RST_MODE;
         cfg_q  <= `ASRA_RST_CFG;
         gpo_q  <= `ASRA_RST_GPO;
         off_q  <= `ASRA_RST_OFF;
         fs_q   <= FS_RESET;
      end else if (wr_ev) begin
         case (wr_addr)
            `ASRA_A_MODE: mode_q <= wr_data;
            `ASRA_A_CFG:  cfg_q  <= wr_data;
            `ASRA_A_GPO:  gpo_q  <= wr_data[7:0];
            `ASRA_A_OFF:  off_q  <= wr_data;
            `ASRA_A_FS:   fs_q   <= wr_data;
            default:      ;
         endcase
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_q <= '0;
         pend_q <= 1'b0;
      end else if (result_valid) begin
         hold_q <= {result, result_flags};
         pend_q <= 1'b1;
      end else if (publish || prst_ev) begin
         pend_q <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_q   <= `ASRA_RST_DATA;
         status_q <= `ASRA_RST_STATUS;
      end else if (prst_ev) begin
         data_q   <= `ASRA_RST_DATA;
         status_q <= `ASRA_RST_STATUS;
      end else if (publish) begin
         data_q   <= hold_q[30:7];
         status_q <= {1'b0, hold_q[6:0]};
      end else if (rd_ev || mode_wr) begin
         status_q[`ASRA_ST_RDY] <= 1'b1;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         filter_restart_q <= 1'b0;
         part_reset_q     <= 1'b0;
         ident_q          <= 8'h00;
      end else begin
         filter_restart_q <= mode_wr;
         part_reset_q     <= prst_ev;
         ident_q          <= PART_ID;
      end
   end
endmodule : asra_regs
`default_nettype wire

// *** core/asra_top.sv ***
/*
 Serial command front-end of a converter: a command byte selects
 direction and one of eight registers, then one access or a continuous data read follows.
 Assumes the host drives sclk (idles high), changes din after the falling
 edge and samples dout on the rising edge.
*/
`default_nettype none
`include "asra_defs.svh"
// Notes on behaviour
// - Each transaction opens with a command byte
// - Back to idle after each access outside continuous read
// - Start idle after power-up or reset
// - Forty ones on din reset everything
// - Gate bit 0 starts command, 1 waits
// - Direction bit picks write or read
// - Three address bits pick the register
// - Continuous read shifts each new result
// - Din watched during continuous reading
// - Command byte arrives msb first
// - Address 0 writes command, reads status
// - Access length is register width; data takes 32 with append
// - Mode write restarts filter, sets ready
module asra_top #(
   // Arbitrary identity value
   parameter logic [7:0]  PART_ID  = 8'h5A,
   parameter logic [23:0] FS_RESET = 24'h000000
) (
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Serial link
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             dout,
   // Converter side
   input  wire logic        result_valid,
   input  wire logic [23:0] result,
   input  wire logic [6:0]  result_flags,
   // Register contents
   output logic [23:0]      operating_mode,
   output logic [23:0]      channel_gain_setup,
   output logic [7:0]       output_port_control,
   output logic [23:0]      zero_calibration,
   output logic [23:0]      gain_calibration,
   output logic [7:0]       status,
   // Events
   output logic             filter_restart,
   output logic             part_reset
);
   import asra_pkg::*;

   // Link-domain state
   asra_state_e state_q, state_d;
   logic [5:0]  cnt_q, cnt_d;
   logic [5:0]  len_q, len_d;
   logic [5:0]  ones_q, ones_d;
   logic [31:0] rx_q, rx_d;
   logic [31:0] tx_q, tx_d;
   asra_addr_t  addr_q, addr_d;
   logic        continuous_read_bit_q, continuous_read_bit_d;
   logic        busy_q, busy_d;
   logic        stale_q, stale_d;
   logic        wr_tgl_q, wr_tgl_d;
   asra_addr_t  wr_addr_q, wr_addr_d;
   logic [23:0] wr_data_q, wr_data_d;
   logic        rd_tgl_q, rd_tgl_d;
   logic        prst_tgl_q, prst_tgl_d;
   logic        rdy_m_q, rdy_s_q;
   logic        dout_q;
   logic        take_cmd;

   // Core-domain registers
   logic [7:0]  status_w;
   logic [23:0] mode_w, cfg_w, data_w, off_w, fs_w;
   logic [7:0]  ident_w, gpo_w;
   logic        restart_w, prst_w;

   asra_regs #(
      .PART_ID  (PART_ID),
      .FS_RESET (FS_RESET)
   ) u_regs (
      .core_clk         (core_clk),
      .sys_rst          (sys_rst),
      .wr_tgl           (wr_tgl_q),
      .wr_addr          (wr_addr_q),
      .wr_data          (wr_data_q),
      .rd_tgl           (rd_tgl_q),
      .prst_tgl         (prst_tgl_q),
      .link_busy        (busy_q),
      .result_valid     (result_valid),
      .result           (result),
      .result_flags     (result_flags),
      .status_q         (status_w),
      .mode_q           (mode_w),
      .cfg_q            (cfg_w),
      .data_q           (data_w),
      .ident_q          (ident_w),
      .gpo_q            (gpo_w),
      .off_q            (off_w),
      .fs_q             (fs_w),
      .filter_restart_q (restart_w),
      .part_reset_q     (prst_w)
   );

   assign operating_mode      = mode_w;
   assign channel_gain_setup  = cfg_w;
   assign output_port_control = gpo_w;
   assign zero_calibration    = off_w;
   assign gain_calibration    = fs_w;
   assign status              = status_w;
   assign filter_restart      = restart_w;
   assign part_reset          = prst_w;
   assign dout                = dout_q;

   // Command byte as it completes on this edge
   // Command msb first
   wire [7:0]  byte_w    = {rx_q[6:0], din};
   wire        cmd_rd_w  = byte_w[`ASRA_CMD_DIR];
   wire [2:0]  cmd_adr_w = byte_w[`ASRA_CMD_AHI:`ASRA_CMD_ALO];
   wire        cmd_cr_w  = byte_w[`ASRA_CMD_CONTINUOUS_READ_BIT];
   wire        cmd_dat_w = (cmd_adr_w == `ASRA_A_DATA);
   wire        append_w  = mode_w[`ASRA_MODE_APPEND];
   // A finished streamed word masks the synced ready until it is seen
   // high again, so a stale low cannot restart the same word
   wire        rdy_w     = rdy_s_q || stale_q;
   wire        last_cmd  = (cnt_q == `ASRA_CMD_LAST);
   wire        last_bit  = (cnt_q == len_q - 6'h01);
   wire        ones_hit  = din && (ones_q == `ASRA_ONES_RESET - 6'h01);
   wire        watch_hit = last_cmd && (byte_w != 8'h00);

   // Word to read, left aligned, and its length
   // Address 0 reads status
   wire        short_w   = (cmd_adr_w == `ASRA_A_CMD) || (cmd_adr_w == `ASRA_A_ID)
                           || (cmd_adr_w == `ASRA_A_GPO);
   wire [31:0] data_word = append_w ? {data_w, status_w} : {data_w, 8'h00};
   wire [31:0] rd_word_w = (cmd_adr_w == `ASRA_A_CMD)  ? {status_w, 24'h000000} :
                           (cmd_adr_w == `ASRA_A_MODE) ? {mode_w, 8'h00} :
                           (cmd_adr_w == `ASRA_A_CFG)  ? {cfg_w, 8'h00} :
                           (cmd_adr_w == `ASRA_A_DATA) ? data_word :
                           (cmd_adr_w == `ASRA_A_ID)   ? {ident_w, 24'h000000} :
                           (cmd_adr_w == `ASRA_A_GPO)  ? {gpo_w, 24'h000000} :
                           (cmd_adr_w == `ASRA_A_OFF)  ? {off_w, 8'h00} :
                                                         {fs_w, 8'h00};
   wire [5:0]  len_w     = short_w ? `ASRA_LEN_BYTE :
                           (cmd_dat_w && append_w) ? `ASRA_LEN_LONG : `ASRA_LEN_WORD;
   wire [5:0]  dlen_w    = append_w ? `ASRA_LEN_LONG : `ASRA_LEN_WORD;

   // Next state of the link engine
   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q + 6'h01;
      len_d      = len_q;
      rx_d       = {rx_q[30:0], din};
      tx_d       = {tx_q[30:0], 1'b0};
      addr_d     = addr_q;
      continuous_read_bit_d    = continuous_read_bit_q;
      wr_tgl_d   = wr_tgl_q;
      wr_addr_d  = wr_addr_q;
      wr_data_d  = wr_data_q;
      rd_tgl_d   = rd_tgl_q;
      prst_tgl_d = prst_tgl_q;
      take_cmd   = 1'b0;
      stale_d    = stale_q && !rdy_s_q;
      ones_d     = din ? ones_q + 6'h01 : 6'h00;
      case (state_q)
         ASRA_IDLE: begin
            cnt_d = 6'h01;
            // Wait on gate bit until 0
            if (!din) begin
               state_d = ASRA_CMD;
            end
         end
         ASRA_CMD: begin
            if (last_cmd) begin
               take_cmd = 1'b1;
            end
         end
         ASRA_WRITE: begin
            if (last_bit) begin
               wr_tgl_d  = ~wr_tgl_q;
               wr_addr_d = addr_q;
               wr_data_d = {rx_q[22:0], din};
               state_d   = ASRA_IDLE;
            end
         end
         ASRA_READ: begin
            if (continuous_read_bit_q && watch_hit) begin
               take_cmd = 1'b1;
            end else if (last_bit) begin
               if (addr_q == `ASRA_A_DATA) begin
                  rd_tgl_d = ~rd_tgl_q;
               end
               state_d = continuous_read_bit_q ? ASRA_CONTINUOUS_READ_BIT : ASRA_IDLE;
               if (continuous_read_bit_q) begin
                  // Command windows restart after each word
                  cnt_d   = 6'h00;
                  stale_d = 1'b1;
               end
            end
         end
         ASRA_CONTINUOUS_READ_BIT: begin
            if (watch_hit) begin
               take_cmd = 1'b1;
            end else if (!rdy_w) begin
               tx_d    = {data_word[30:0], 1'b0};
               len_d   = dlen_w;
               addr_d  = `ASRA_A_DATA;
               cnt_d   = 6'h01;
               rx_d    = {31'h00000000, din};
               state_d = ASRA_READ;
            end else if (last_cmd) begin
               cnt_d = 6'h00;
            end
         end
         default: begin
            state_d = ASRA_IDLE;
         end
      endcase
      if (take_cmd) begin
         addr_d  = cmd_adr_w;
         len_d   = len_w;
         cnt_d   = 6'h00;
         continuous_read_bit_d = cmd_rd_w && cmd_dat_w && cmd_cr_w;
         if (cmd_rd_w && cmd_dat_w && cmd_cr_w) begin
            state_d = ASRA_CONTINUOUS_READ_BIT;
         end else if (cmd_rd_w) begin
            tx_d    = rd_word_w;
            state_d = ASRA_READ;
         end else if (cmd_adr_w == `ASRA_A_CMD) begin
            state_d = ASRA_IDLE;
         end else begin
            state_d = ASRA_WRITE;
         end
      end
      if (ones_hit) begin
         state_d    = ASRA_IDLE;
         continuous_read_bit_d    = 1'b0;
         ones_d     = 6'h00;
         prst_tgl_d = ~prst_tgl_q;
         stale_d    = 1'b0;
      end
      // Results wait while the link still owes a ready-high sighting;
      // publishing earlier could hide a result from streaming
      busy_d = (state_d == ASRA_CMD) || (state_d == ASRA_WRITE) || (state_d == ASRA_READ)
               || stale_d;
   end

   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ASRA_IDLE;
         cnt_q   <= 6'h00;
         len_q   <= `ASRA_LEN_BYTE;
         ones_q  <= 6'h00;
         continuous_read_bit_q <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         len_q   <= len_d;
         ones_q  <= ones_d;
         continuous_read_bit_q <= continuous_read_bit_d;
         busy_q  <= busy_d;
      end
   end

   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_q   <= 32'h00000000;
         tx_q   <= 32'h00000000;
         addr_q <= `ASRA_A_CMD;
      end else begin
         rx_q   <= rx_d;
         tx_q   <= tx_d;
         addr_q <= addr_d;
      end
   end

   // Events to the core domain, held until the next one
   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_tgl_q   <= 1'b0;
         wr_addr_q  <= `ASRA_A_CMD;
         wr_data_q  <= 24'h000000;
         rd_tgl_q   <= 1'b0;
         prst_tgl_q <= 1'b0;
      end else begin
         wr_tgl_q   <= wr_tgl_d;
         wr_addr_q  <= wr_addr_d;
         wr_data_q  <= wr_data_d;
         rd_tgl_q   <= rd_tgl_d;
         prst_tgl_q <= prst_tgl_d;
      end
   end

   // Ready flag brought onto the link clock
   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdy_m_q <= 1'b1;
         rdy_s_q <= 1'b1;
      end else begin
         rdy_m_q <= status_w[`ASRA_ST_RDY];
         rdy_s_q <= rdy_m_q;
      end
   end

   // Streamed-word mask, cleared once ready is seen high
   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         stale_q <= 1'b0;
      end else begin
         stale_q <= stale_d;
      end
   end

   // Output bit changes on the falling edge; ready shown when not shifting
   wire dout_w = (state_q == ASRA_READ) ? tx_q[31] :
                 ((state_q == ASRA_CONTINUOUS_READ_BIT) && !rdy_w) ? data_word[31] : rdy_w;

   always_ff @(negedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         dout_q <= 1'b1;
      end else begin
         dout_q <= dout_w;
      end
   end
endmodule : asra_top
`default_nettype wire

// *** tb/asra_host.sv ***
/*
 Host model: serial master for the front-end, one frame per call.
 Assumes the device samples din on the rising sclk edge and moves dout on the falling edge.
*/
`default_nettype none
module asra_host (
   // Serial link toward the device
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b1;
      din  = 1'b1;
   end
   // msb first, one bit per clock
   task automatic frame(input int n, input logic [39:0] tx, output logic [39:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         sclk  = 1'b0;
         din   = tx[i];
         #7.5;
         sclk  = 1'b1;
         rx[i] = dout;
         #7.5;
      end
      // din idles high, sclk stands still
      din = 1'b1;
   endtask : frame
endmodule : asra_host
`default_nettype wire

// *** tb/asra_chk.sv ***
/*
 Concurrent checks on the front-end ports.
 Assumes asra_defs.svh on the include path and binding to asra_top.
*/
`default_nettype none
`include "asra_defs.svh"
module asra_chk (
   // Clocks and reset
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        sclk,
   // Watched ports
   input wire logic        din,
   input wire logic        result_valid,
   input wire logic [6:0]  result_flags,
   input wire logic [23:0] operating_mode,
   input wire logic [23:0] zero_calibration,
   input wire logic [7:0]  status,
   input wire logic        filter_restart,
   input wire logic        part_reset
);
   logic [5:0] ones_q;
   logic [6:0] flags_q;
   // Consecutive ones seen on din
   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) ones_q <= 6'h00;
      else if (!din) ones_q <= 6'h00;
      else if (ones_q != `ASRA_ONES_RESET) ones_q <= ones_q + 6'h01;
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) flags_q <= 7'h00;
      else if (result_valid) flags_q <= result_flags;
   end
   a_reset_vals: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> status == `ASRA_RST_STATUS && operating_mode == `ASRA_RST_MODE)
      else $error("register values wrong after reset");
   a_result_rdy: assert property (@(posedge core_clk) disable iff (sys_rst)
      result_valid |-> ##[1:80] !status[`ASRA_ST_RDY])
      else $error("new result never cleared ready");
   a_flags_publish: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(status[`ASRA_ST_RDY]) |-> status[6:0] == flags_q)
      else $error("status flags differ from last result");
   a_mode_ready: assert property (@(posedge core_clk) disable iff (sys_rst)
      filter_restart && !result_valid |-> ##[0:2] status[`ASRA_ST_RDY])
      else $error("mode write left ready clear");
   a_restart_once: assert property (@(posedge core_clk) disable iff (sys_rst)
      filter_restart |=> !filter_restart)
      else $error("filter restart longer than one cycle");
   a_preset_once: assert property (@(posedge core_clk) disable iff (sys_rst)
      part_reset |=> !part_reset)
      else $error("part reset longer than one cycle");
   a_preset_vals: assert property (@(posedge core_clk) disable iff (sys_rst)
      part_reset |-> ##[0:2] (operating_mode == `ASRA_RST_MODE && zero_calibration == `ASRA_RST_OFF
      && status == `ASRA_RST_STATUS))
      else $error("registers not reset by part reset");
   a_ones_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
      part_reset |-> ones_q == `ASRA_ONES_RESET)
      else $error("part reset without forty ones");
   a_ones_fire: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(ones_q == `ASRA_ONES_RESET) |-> ##[0:12] part_reset)
      else $error("forty ones gave no part reset");
endmodule : asra_chk
bind asra_top asra_chk asra_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .din(din),
   .result_valid(result_valid), .result_flags(result_flags), .operating_mode(operating_mode),
   .zero_calibration(zero_calibration), .status(status), .filter_restart(filter_restart),
   .part_reset(part_reset));
`default_nettype wire

// *** tb/tb.sv ***
/*
 Testbench: register accesses through the host model, results from the converter side.
 Assumes asra_defs.svh on the include path.
*/
`default_nettype none
`include "asra_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("Error %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary identity value
   localparam logic [7:0] TB_ID = 8'hC3;
   logic        core_clk;
   logic        sys_rst;
   wire         sclk;
   wire         din;
   logic        dout;
   logic        result_valid;
   logic [23:0] result;
   logic [6:0]  result_flags;
   logic [23:0] operating_mode;
   logic [23:0] channel_gain_setup;
   logic [7:0]  output_port_control;
   logic [23:0] zero_calibration;
   logic [23:0] gain_calibration;
   logic [7:0]  status;
   logic        filter_restart;
   logic        part_reset;
   logic [39:0] rx;
   logic [31:0] v;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_restart = 0;
   logic        seen_preset = 1'b0;
   logic [2:0]  rw_a [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
   logic [23:0] rw_rst [5] = '{`ASRA_RST_MODE, `ASRA_RST_CFG, 24'(`ASRA_RST_GPO), `ASRA_RST_OFF, 24'h000000};
   logic [23:0] rw_val [5] = '{24'h0A5A5A, 24'h3C00C3, 24'h0000A5, 24'h7E8181, 24'h00F00F};
   asra_top #(.PART_ID(TB_ID)) asra_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk),
      .din(din), .dout(dout), .result_valid(result_valid), .result(result), .result_flags(result_flags),
      .operating_mode(operating_mode), .channel_gain_setup(channel_gain_setup),
      .output_port_control(output_port_control), .zero_calibration(zero_calibration),
      .gain_calibration(gain_calibration), .status(status), .filter_restart(filter_restart),
      .part_reset(part_reset));
   asra_host asra_host_i (.sclk(sclk), .din(din), .dout(dout));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (filter_restart === 1'b1) n_restart++;
   always @(posedge core_clk) if (part_reset === 1'b1) seen_preset = 1'b1;
   // gate bit 0, low bits 0
   function automatic logic [7:0] cmd(input logic rd, input logic [2:0] a, input logic cr);
      return {1'b0, rd, a, cr, 2'b00};
   endfunction : cmd
   function automatic int wid(input logic [2:0] a);
      return (a == `ASRA_A_CMD || a == `ASRA_A_ID || a == `ASRA_A_GPO) ? 8 : 24;
   endfunction : wid
   function automatic logic [23:0] port(input logic [2:0] a);
      case (a)
         `ASRA_A_MODE: return operating_mode;
         `ASRA_A_CFG:  return channel_gain_setup;
         `ASRA_A_GPO:  return {16'h0000, output_port_control};
         `ASRA_A_OFF:  return zero_calibration;
         default:      return gain_calibration;
      endcase
   endfunction : port
   task automatic xf(input int n, input logic [39:0] tx, input int w);
      asra_host_i.frame(n, tx, rx);
      v = 32'(rx & ((40'h1 << w) - 40'h1));
      repeat (8) @(posedge core_clk);
   endtask : xf
   task automatic wr(input logic [2:0] a, input logic [23:0] d);
      xf(8 + wid(a), (40'(cmd(1'b0, a, 1'b0)) << wid(a)) | 40'(d), 0);
   endtask : wr
   task automatic rd(input logic [2:0] a, input int w);
      xf(8 + w, 40'(cmd(1'b1, a, 1'b0)) << w, w);
   endtask : rd
   task automatic post(input logic [23:0] r, input logic [6:0] f);
      result_valid <= 1'b1;
      result       <= r;
      result_flags <= f;
      @(posedge core_clk);
      result_valid <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : post
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      sys_rst      = 1'b1;
      result_valid = 1'b0;
      result       = 24'h000000;
      result_flags = 7'h00;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 5; i++) `CHK(port(rw_a[i]), rw_rst[i])
      `CHK(status, `ASRA_RST_STATUS)
      rd(`ASRA_A_CMD, 8);
      `CHK(v[7:0], `ASRA_RST_STATUS)
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wr(rw_a[i], rw_val[i]);
         `CHK(port(rw_a[i]), rw_val[i])
         rd(rw_a[i], wid(rw_a[i]));
         `CHK(v[23:0], rw_val[i])
      end
      `CHK(n_restart, 1)
      $display("test registers done");
      xf(19, {21'h0, 3'b111, cmd(1'b0, `ASRA_A_GPO, 1'b0), 8'h3C}, 0);
      `CHK(output_port_control, 8'h3C)
      xf(8, 40'(cmd(1'b0, `ASRA_A_CMD, 1'b0)), 0);
      wr(`ASRA_A_ID, 24'h0000FF);
      wr(`ASRA_A_DATA, 24'h111111);
      rd(`ASRA_A_ID, 8);
      `CHK(v[7:0], TB_ID)
      $display("test gate and refused done");
      post(24'hABCDEF, 7'h15);
      `CHK(status, 8'h15)
      rd(`ASRA_A_CMD, 8);
      `CHK(v[7:0], 8'h15)
      rd(`ASRA_A_DATA, 24);
      `CHK(v[23:0], 24'hABCDEF)
      `CHK(status, 8'h95)
      $display("test result done");
      post(24'h13579B, 7'h02);
      xf(8, 40'(cmd(1'b1, `ASRA_A_DATA, 1'b1)), 0);
      xf(24, 40'h0, 24);
      `CHK(v[23:0], 24'h13579B)
      `CHK(status, 8'h82)
      xf(24, 40'(cmd(1'b1, `ASRA_A_CMD, 1'b0)) << 8, 8);
      `CHK(v[7:0], 8'h82)
      rd(`ASRA_A_ID, 8);
      `CHK(v[7:0], TB_ID)
      $display("test continuous read done");
      post(24'h000001, 7'h01);
      wr(`ASRA_A_MODE, 24'h180060);
      `CHK(status[`ASRA_ST_RDY], 1'b1)
      post(24'h2468AC, 7'h0B);
      rd(`ASRA_A_DATA, 32);
      `CHK(v, 32'h2468AC0B)
      $display("test append done");
      asra_host_i.frame(40, {40{1'b1}}, rx);
      for (int i = 0; i < 50 && !seen_preset; i++) @(posedge core_clk);
      if (!seen_preset) begin
         n_fail++;
         $display("Error %0t: no part reset after forty ones", $time);
      end else begin
         repeat (4) @(posedge core_clk);
         `CHK(operating_mode, `ASRA_RST_MODE)
         `CHK(output_port_control, `ASRA_RST_GPO)
         rd(`ASRA_A_CMD, 8);
         `CHK(v[7:0], `ASRA_RST_STATUS)
      end
      $display("test forty ones done");
      final_report();
   end
endmodule : tb
`default_nettype wire
